// ==== common/scpc_pkg.sv ====
// Shared constants and carrier types for the solenoid channel protection control
package scpc_pkg;
  localparam int CLOCK_MHZ = 200;
  // Glitch filter on the overvoltage trip, nanoseconds
  localparam int OV_FILTER_NS = 6500;
  localparam int OV_FILTER_CYC = (OV_FILTER_NS * CLOCK_MHZ) / 1000;
  // Short sense time, microseconds (typical)
  localparam int SENSE_US = 60;
  localparam int SENSE_CYC = SENSE_US * CLOCK_MHZ;
  // Refresh off time, milliseconds (typical)
  localparam int REFRESH_MS = 14;
  localparam int REFRESH_CYC = REFRESH_MS * 1000 * CLOCK_MHZ;
  // Blanking after off-to-on, nanoseconds
  localparam int BLANK_NS = 5000;
  localparam int BLANK_CYC = (BLANK_NS * CLOCK_MHZ) / 1000;
  // Commanded current code equal to 50 mA
  localparam logic [9:0] MIN_CURRENT_CODE = 10'h033;
  localparam logic [1:0] SLEW_RESET = 2'h0;
  localparam logic [9:0] CURRENT_RESET = 10'h000;

  typedef struct packed {
    logic [9:0] current;
    logic [1:0] slew;
  } scpc_setting_t;

  typedef enum logic [1:0] {
    SCPC_RUN,
    SCPC_SENSE,
    SCPC_REFRESH
  } scpc_state_t;
endpackage

// ==== logic/scpc_top.sv ====
// Overvoltage and per-channel overcurrent protection with output control
//
// Summary of operation
// - Overvoltage acts only after 6.5 us filter.
// - Filtered overvoltage turns off both channels.
// - Commands accepted, outputs held off meanwhile.
// - Outputs resume automatically when overvoltage clears.
// - Overvoltage keeps settings; dither keeps running.
// - Comparator watched only while drive on.
// - Overcurrent shutdown latches flag until read.
// - Driver off for refresh, then retries.
// - Persistent fault repeats shutdown and refresh.
// - Comparator ignored for blanking after turn-on.
// - Commands during refresh stored, applied later.
// - Protection state kept separately per channel.
// - No overcurrent detection below 50 mA.
// - Slew code 0 to 3 per output.
// - Sense 60 us, refresh 14 ms typical.
// - Default input zeroes, resets, ignores, keeps flags.
`timescale 1ns/10ps
`default_nettype none
module scpc_top #(
  parameter int CHANNELS = 2,
  parameter int OV_FILTER_CYCLES = scpc_pkg::OV_FILTER_CYC,
  parameter int SENSE_CYCLES = scpc_pkg::SENSE_CYC,
  parameter int REFRESH_CYCLES = scpc_pkg::REFRESH_CYC,
  parameter int BLANK_CYCLES = scpc_pkg::BLANK_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic overvoltage_trip,
  input wire logic default_mode,
  input wire logic [CHANNELS-1:0] overcurrent_compare,
  input wire logic [CHANNELS-1:0] gate_request,
  input wire logic [CHANNELS-1:0] cmd_write,
  input wire scpc_pkg::scpc_setting_t [CHANNELS-1:0] cmd_setting,
  input wire logic fault_read,
  output logic [CHANNELS-1:0] channel_drive_output,
  output scpc_pkg::scpc_setting_t [CHANNELS-1:0] active_setting,
  output logic [CHANNELS-1:0] overcurrent_fault_flag,
  output logic overvoltage_shutdown,
  output logic serial_out_enable,
  output logic [15:0] dither_count
);
  localparam int CW = 32;

  // Refused at elaboration: a zero count leaves a filter or timer with no length
  if (CHANNELS < 1 || OV_FILTER_CYCLES < 1 || SENSE_CYCLES < 1
      || REFRESH_CYCLES < 1 || BLANK_CYCLES < 1) begin : g_bad_params
    $error("scpc_top: counts and channel number must be at least one");
  end

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [CHANNELS+1:0] sync_a, sync_b;
  logic [CHANNELS+1:0] next_sync_a;
  logic ov_s, dflt_s;
  logic [CHANNELS-1:0] oc_s;

  always_comb begin
    next_sync_a = {default_mode, overvoltage_trip, overcurrent_compare};
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= sync_a;
    end
  end
  assign oc_s = sync_b[CHANNELS-1:0];
  assign ov_s = sync_b[CHANNELS];
  assign dflt_s = sync_b[CHANNELS+1];

  // ************************************************************
  // Overvoltage filter
  // ************************************************************
  logic [CW-1:0] ov_cnt, next_ov_cnt;
  logic ov_off, next_ov_off;

  always_comb begin
    next_ov_cnt = '0;
    next_ov_off = 1'b0;
    if (ov_s) begin
      next_ov_off = ov_off;
      next_ov_cnt = ov_cnt;
      if (ov_cnt >= CW'(OV_FILTER_CYCLES - 1)) begin
        next_ov_off = 1'b1;
      end else begin
        next_ov_cnt = ov_cnt + CW'(1);
      end
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ov_cnt <= '0;
      ov_off <= 1'b0;
    end else begin
      ov_cnt <= next_ov_cnt;
      ov_off <= next_ov_off;
    end
  end

  // ************************************************************
  // Settings, dither counter, serial output enable
  // ************************************************************
  scpc_pkg::scpc_setting_t [CHANNELS-1:0] stored, next_stored;
  logic [15:0] next_dither;
  logic next_so_en;

  always_comb begin
    next_stored = stored;
    next_dither = dither_count + 16'h0001;
    next_so_en = ~dflt_s;
    for (int i = 0; i < CHANNELS; i++) begin
      if (dflt_s) begin
        next_stored[i] = '{current: scpc_pkg::CURRENT_RESET, slew: scpc_pkg::SLEW_RESET};
      end else if (cmd_write[i]) begin
        next_stored[i] = cmd_setting[i];
      end
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        stored[i] <= '{current: scpc_pkg::CURRENT_RESET, slew: scpc_pkg::SLEW_RESET};
      end
      dither_count <= 16'h0000;
      serial_out_enable <= 1'b0;
    end else begin
      stored <= next_stored;
      dither_count <= next_dither;
      serial_out_enable <= next_so_en;
    end
  end

  // ************************************************************
  // Per-channel overcurrent protection
  // ************************************************************
  scpc_pkg::scpc_state_t [CHANNELS-1:0] st, next_st;
  logic [CHANNELS-1:0][CW-1:0] cnt, next_cnt, blank, next_blank;
  logic [CHANNELS-1:0] flag, next_flag, drive, next_drive;
  scpc_pkg::scpc_setting_t [CHANNELS-1:0] act, next_act;

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_blank = blank;
    next_flag = flag;
    next_drive = '0;
    next_act = act;
    for (int i = 0; i < CHANNELS; i++) begin
      logic gate_on, armed, trip;
      gate_on = 1'b0;
      armed = 1'b0;
      trip = 1'b0;
      // Hold new setting back during refresh
      if (st[i] != scpc_pkg::SCPC_REFRESH) begin
        next_act[i] = next_stored[i];
      end
      gate_on = gate_request[i] && !ov_off && !dflt_s && st[i] != scpc_pkg::SCPC_REFRESH
                && act[i].current != scpc_pkg::CURRENT_RESET;
      if (gate_on && !drive[i]) begin
        next_blank[i] = CW'(BLANK_CYCLES);
      end else if (blank[i] != '0) begin
        next_blank[i] = blank[i] - CW'(1);
      end
      armed = drive[i] && gate_on && blank[i] == '0 && oc_s[i]
              && act[i].current >= scpc_pkg::MIN_CURRENT_CODE;
      next_drive[i] = gate_on;
      unique case (st[i])
        scpc_pkg::SCPC_RUN: begin
          next_cnt[i] = '0;
          if (armed) begin
            next_st[i] = scpc_pkg::SCPC_SENSE;
            next_cnt[i] = CW'(1);
          end
        end
        scpc_pkg::SCPC_SENSE: begin
          if (!armed) begin
            next_st[i] = scpc_pkg::SCPC_RUN;
            next_cnt[i] = '0;
          end else if (cnt[i] >= CW'(SENSE_CYCLES)) begin
            trip = 1'b1;
            next_st[i] = scpc_pkg::SCPC_REFRESH;
            next_cnt[i] = '0;
            next_drive[i] = 1'b0;
          end else begin
            next_cnt[i] = cnt[i] + CW'(1);
          end
        end
        scpc_pkg::SCPC_REFRESH: begin
          next_drive[i] = 1'b0;
          if (cnt[i] >= CW'(REFRESH_CYCLES - 1)) begin
            next_st[i] = scpc_pkg::SCPC_RUN;
            next_cnt[i] = '0;
          end else begin
            next_cnt[i] = cnt[i] + CW'(1);
          end
        end
      endcase
      // New event beats the read clear
      if (trip) begin
        next_flag[i] = 1'b1;
      end else if (fault_read && !dflt_s) begin
        next_flag[i] = 1'b0;
      end
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        st[i] <= scpc_pkg::SCPC_RUN;
        act[i] <= '{current: scpc_pkg::CURRENT_RESET, slew: scpc_pkg::SLEW_RESET};
      end
      cnt <= '0;
      blank <= '0;
      flag <= '0;
      drive <= '0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      blank <= next_blank;
      flag <= next_flag;
      drive <= next_drive;
      act <= next_act;
    end
  end

  assign channel_drive_output = drive;
  assign overcurrent_fault_flag = flag;
  assign active_setting = act;
  assign overvoltage_shutdown = ov_off;
endmodule // scpc_top
`default_nettype wire

// ==== testbench/scpc_top_asserts.sv ====
// Checker for protection timing at the top module's ports
`timescale 1ns/10ps
`default_nettype none
module scpc_top_asserts #(
  parameter int CHANNELS = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic overvoltage_trip,
  input wire logic default_mode,
  input wire logic fault_read,
  input wire logic [CHANNELS-1:0] channel_drive_output,
  input wire scpc_pkg::scpc_setting_t [CHANNELS-1:0] active_setting,
  input wire logic [CHANNELS-1:0] overcurrent_fault_flag,
  input wire logic overvoltage_shutdown,
  input wire logic serial_out_enable,
  input wire logic [15:0] dither_count
);
  // ****************
  // Port relations
  // ****************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Holds for filter lengths of four cycles or more
  a_ov_filter: assert property ($rose(overvoltage_shutdown) |->
    $past(overvoltage_trip, 3) && $past(overvoltage_trip, 4) && $past(overvoltage_trip, 5)
    && $past(overvoltage_trip, 6))
    else $error("shutdown without a held trip");
  a_ov_off: assert property (overvoltage_shutdown && $past(overvoltage_shutdown) |-> channel_drive_output == '0)
    else $error("drive on during overvoltage");
  a_dither_run: assert property (overvoltage_shutdown |-> dither_count != $past(dither_count))
    else $error("dither stopped");
  a_flag_drop: assert property ($rose(overcurrent_fault_flag[0]) |-> $fell(channel_drive_output[0]))
    else $error("flag set without shutdown");
  a_refresh_off: assert property ($rose(overcurrent_fault_flag[0]) |=> !channel_drive_output[0] [*8])
    else $error("drive back too early");
  // Read clears the flag at the edge that takes it
  a_flag_keep: assert property ($fell(overcurrent_fault_flag[0]) |->
    $past(fault_read))
    else $error("flag cleared without read");
  a_def_quiet: assert property (default_mode [*4] |-> !serial_out_enable && active_setting == '0)
    else $error("default mode not quiet");
  a_low_cur: assert property ($past(active_setting[0].current) < scpc_pkg::MIN_CURRENT_CODE
    |-> !$rose(overcurrent_fault_flag[0]))
    else $error("flag at low current");
endmodule // scpc_top_asserts
bind scpc_top scpc_top_asserts #(.CHANNELS(CHANNELS)) i_chk (.clock(clock), .rst(rst),
  .overvoltage_trip(overvoltage_trip), .default_mode(default_mode), .fault_read(fault_read),
  .channel_drive_output(channel_drive_output), .active_setting(active_setting),
  .overcurrent_fault_flag(overcurrent_fault_flag), .overvoltage_shutdown(overvoltage_shutdown),
  .serial_out_enable(serial_out_enable), .dither_count(dither_count));
`default_nettype wire

// ==== testbench/scpc_host_model.sv ====
// Host model issuing decoded serial commands and fault reads
`timescale 1ns/10ps
`default_nettype none
module scpc_host_model #(
  parameter int CHANNELS = 2
) (
  input wire logic clock,
  output logic [CHANNELS-1:0] cmd_write,
  output scpc_pkg::scpc_setting_t [CHANNELS-1:0] cmd_setting,
  output logic fault_read
);
  // ****************
  // Command tasks
  // ****************
  initial begin
    cmd_write = '0;
    cmd_setting = '0;
    fault_read = 1'b0;
  end
  task automatic write(input int ch, input logic [11:0] value);
    @(posedge clock);
    cmd_setting[ch] <= value;
    cmd_write[ch] <= 1'b1;
    @(posedge clock);
    cmd_write[ch] <= 1'b0;
    // Stale data scrambled so a late capture shows
    cmd_setting[ch] <= ~value;
  endtask
  task automatic read;
    @(posedge clock);
    fault_read <= 1'b1;
    @(posedge clock);
    fault_read <= 1'b0;
  endtask
endmodule // scpc_host_model
`default_nettype wire

// ==== testbench/tb_solenoid_channel_protection_ctrl.sv ====
// Self-checking bench for the solenoid protection control
`timescale 1ns/10ps
`default_nettype none
module tb_solenoid_channel_protection_ctrl;
  logic clock;
  logic rst;
  logic trip;
  logic dflt;
  logic [1:0] comp;
  logic [1:0] gate;
  logic [1:0] wr;
  scpc_pkg::scpc_setting_t [1:0] cset;
  logic rd;
  logic [1:0] drive;
  scpc_pkg::scpc_setting_t [1:0] setting;
  logic [1:0] flag;
  logic ovs;
  logic soe;
  logic [15:0] dith;
  logic [15:0] dith_start;
  int miscompares = 0;
  int tests_run = 0;
  // Each row: written setting, then the setting expected in effect
  logic [23:0] rows [4] = '{24'h400400, 24'h401401, 24'h402402, 24'h403403};
  scpc_top #(.OV_FILTER_CYCLES(4), .SENSE_CYCLES(8), .REFRESH_CYCLES(20), .BLANK_CYCLES(3)) i_dut (
    .clock(clock), .rst(rst), .overvoltage_trip(trip), .default_mode(dflt), .overcurrent_compare(comp),
    .gate_request(gate), .cmd_write(wr), .cmd_setting(cset), .fault_read(rd), .channel_drive_output(drive),
    .active_setting(setting), .overcurrent_fault_flag(flag), .overvoltage_shutdown(ovs),
    .serial_out_enable(soe), .dither_count(dith));
  scpc_host_model i_host (.clock(clock), .cmd_write(wr), .cmd_setting(cset), .fault_read(rd));
  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_drive(input int ch, input logic val);
    int n;
    n = 0;
    while (drive[ch] !== val && n < 60) begin
      tick(1);
      n++;
    end
    chk(16'(n < 60), 16'h0001);
    if (n == 60) begin
      summarize();
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    rst = 1'b1;
    trip = 1'b0;
    dflt = 1'b0;
    comp = 2'h0;
    gate = 2'h3;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    tick(6);
    chk(soe, 1'b1);
    i_host.write(1, 12'h400);
    foreach (rows[i]) begin
      i_host.write(0, rows[i][23:12]);
      tick(3);
      chk(setting[0], rows[i][11:0]);
    end
    wait_drive(0, 1'b1);
    wait_drive(1, 1'b1);
    // Spike shorter than the filter
    @(posedge clock) trip <= 1'b1;
    @(posedge clock) trip <= 1'b0;
    tick(10);
    chk(ovs, 1'b0);
    @(posedge clock) trip <= 1'b1;
    wait_drive(0, 1'b0);
    chk(drive, 2'h0);
    i_host.write(1, 12'h404);
    tick(4);
    chk(setting[1], 12'h404);
    chk(setting[0], 12'h403);
    chk(drive, 2'h0);
    // Dither advances once per clock during overvoltage
    dith_start = dith;
    tick(4);
    chk(dith - dith_start, 16'h0004);
    @(posedge clock) trip <= 1'b0;
    wait_drive(0, 1'b1);
    wait_drive(1, 1'b1);
    @(posedge clock) comp <= 2'h1;
    wait_drive(0, 1'b0);
    chk(flag, 2'h1);
    chk(drive[1], 1'b1);
    i_host.write(0, 12'h800);
    tick(4);
    chk(setting[0], 12'h403);
    chk(drive[0], 1'b0);
    wait_drive(0, 1'b1);
    chk(setting[0], 12'h800);
    wait_drive(0, 1'b0);
    @(posedge clock) comp <= 2'h0;
    wait_drive(0, 1'b1);
    tick(20);
    chk(drive[0], 1'b1);
    i_host.write(1, 12'h040);
    @(posedge clock) comp <= 2'h2;
    tick(40);
    chk(flag, 2'h1);
    @(posedge clock) comp <= 2'h0;
    @(posedge clock) dflt <= 1'b1;
    tick(4);
    i_host.write(0, 12'h400);
    i_host.read();
    tick(4);
    chk({setting[0], soe, flag}, 15'h0001);
    @(posedge clock) dflt <= 1'b0;
    tick(4);
    i_host.read();
    tick(4);
    chk(flag, 2'h0);
    // Gate request low: comparator must be ignored
    @(posedge clock) gate <= 2'h2;
    comp <= 2'h1;
    i_host.write(0, 12'h400);
    tick(30);
    chk({drive, flag}, 4'h0);
    // Turn-on with the comparator already high
    @(posedge clock) gate <= 2'h3;
    wait_drive(0, 1'b1);
    tick(10);
    chk(drive[0], 1'b1);
    wait_drive(0, 1'b0);
    chk(flag, 2'h1);
    summarize();
  end
endmodule // tb_solenoid_channel_protection_ctrl
`default_nettype wire
